//--- core/lmx_pkg.sv
// Constants for the LED matrix control and status register bank.
// Assumes an 8-bit register port with byte addresses from the serial port.
package lmx_pkg;
    localparam logic [7:0] LMX_ADDR_STATUS = 8'h1A;
    localparam logic [7:0] LMX_ADDR_MASK = 8'h1B;
    localparam logic [7:0] LMX_ADDR_DETECT = 8'h1C;
    localparam logic [7:0] LMX_ADDR_DRV_EN = 8'h1D;
    localparam logic [7:0] LMX_ADDR_PWM1 = 8'h1E;
    localparam logic [7:0] LMX_ADDR_PWM7 = 8'h24;
    localparam logic [7:0] LMX_ADDR_SCALE = 8'h25;
    localparam logic [7:0] LMX_ADDR_SEL_FIRST = 8'h2D;
    localparam logic [7:0] LMX_ADDR_SEL_LAST = 8'h74;
    localparam logic [7:0] LMX_RST_STATUS = 8'h00;
    localparam logic [7:0] LMX_RST_MASK = 8'h0F;
    localparam logic [7:0] LMX_RST_ZERO = 8'h00;
    localparam int LMX_BIT_TEST = 3;
    localparam int LMX_BIT_OPEN = 2;
    localparam int LMX_BIT_SHORT = 1;
    localparam int LMX_BIT_FRAME = 0;
    localparam int LMX_BIT_FADE_DBL = 7;
    localparam int LMX_BIT_PWM_ON = 6;
    localparam int LMX_NUM_DRV = 7;
    localparam int LMX_DUTY_W = 6;
    localparam int LMX_NUM_SEL = 72;
    localparam logic [2:0] LMX_SEL_DET_ON = 3'h4;
    localparam logic [2:0] LMX_SEL_OPEN = 3'h5;
    localparam logic [2:0] LMX_SEL_SHORT = 3'h6;
    localparam logic [1:0] LMX_SCALE_X1 = 2'h0;
    localparam logic [1:0] LMX_SCALE_QTR = 2'h1;
    localparam logic [1:0] LMX_SCALE_HALF = 2'h2;
    localparam logic [1:0] LMX_SCALE_X2 = 2'h3;
    localparam int LMX_STEP_NS = 1000;
    localparam int LMX_CLK_NS = 4;
    localparam int LMX_STEP_CYC = (LMX_STEP_NS + LMX_CLK_NS - 1) / LMX_CLK_NS;
endpackage : lmx_pkg

//--- core/lmx_pwm.sv
// One shared LED driver: PWM duty counter with fade or firefly ramping.
// Assumes a one-cycle step enable from the register bank's divider.
`timescale 1ns/10ps
module lmx_pwm #(
    parameter int DUTY_W = 6
) (
    input wire logic mclk_in, // System clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic step_in, // Time base pulse
    input wire logic on_in, // Driver enabled
    input wire logic pwm_on_in, // PWM mode, else firefly
    input wire logic [DUTY_W-1:0] duty_in, // Target duty code
    input wire logic [2:0] time_in, // Step delay in both modes
    input wire logic fade_dbl_in, // Doubles the PWM-mode step delay while up_q is low
    input wire logic [1:0] hi_scale_in, // Max-duty time scale
    input wire logic [1:0] lo_scale_in, // Time scale at every level below max duty
    output logic drive_out // Driver gate
);
    logic [DUTY_W-1:0] phase_q;
    logic [DUTY_W-1:0] level_q;
    logic [DUTY_W-1:0] level_d;
    logic [9:0] wait_q;
    logic [9:0] wait_d;
    logic up_q;
    logic up_d;
    logic [9:0] base;
    logic [9:0] delay;
    logic at_top;
    logic at_bot;
    logic [1:0] scale;

    // Scale a base count by a two-bit code
    function automatic logic [9:0] lmx_scale(input logic [9:0] b,
                                             input logic [1:0] c);
        case (c)
            lmx_pkg::LMX_SCALE_QTR: lmx_scale = b >> 2;
            lmx_pkg::LMX_SCALE_HALF: lmx_scale = b >> 1;
            lmx_pkg::LMX_SCALE_X2: lmx_scale = b << 1;
            default: lmx_scale = b;
        endcase
    endfunction : lmx_scale

    // Step delay; zero code means instant change
    assign base = {5'h00, time_in, 2'h0};
    assign at_top = level_q == duty_in;
    assign at_bot = level_q == '0;
    // Firefly dwell at the extremes uses the shared scales
    assign scale = at_top ? hi_scale_in
        : lo_scale_in;
    // Doubled PWM-mode delay when asked and up_q is low; firefly ignores fade_dbl_in and uses the scales
    assign delay = pwm_on_in
        ? ((!up_q && fade_dbl_in) ? (base << 1) : base)
        : lmx_scale(base, scale);

    // Set level to duty after the step delay, or bounce in firefly mode
    always_comb
    begin
        level_d = level_q;
        wait_d = wait_q;
        up_d = up_q;
        if (!on_in)
        begin
            level_d = '0;
            up_d = 1'b1;
        end
        else if (step_in)
        begin
            if (wait_q != '0)
                wait_d = wait_q - 10'h001;
            else
            begin
                wait_d = delay;
                if (pwm_on_in)
                    level_d = duty_in;
                else if (up_q)
                begin
                    if (at_top)
                        up_d = 1'b0;
                    else
                        level_d = level_q + 1'b1;
                end
                else if (at_bot)
                    up_d = 1'b1;
                else
                    level_d = level_q - 1'b1;
            end
        end
    end

    // Duty compare: code over 64 of the period
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            phase_q <= '0;
            level_q <= '0;
            wait_q <= '0;
            up_q <= 1'b1;
            drive_out <= 1'b0;
        end
        else
        begin
            phase_q <= phase_q + 1'b1;
            level_q <= level_d;
            wait_q <= wait_d;
            up_q <= up_d;
            drive_out <= on_in && (phase_q < level_q);
        end
    end
endmodule : lmx_pwm

//--- core/lmx_regs.sv
// Control and status register bank of the LED matrix driver.
// Assumes a decoded byte register port from the serial interface and
// one-cycle event pulses from the matrix scan and detection logic.
`timescale 1ns/10ps
module lmx_regs #(
    parameter int NUM_DRV = lmx_pkg::LMX_NUM_DRV,
    parameter int DUTY_W = lmx_pkg::LMX_DUTY_W
) (
    input wire logic mclk_in, // System clock, 250 MHz
    input wire logic rst_n_in, // Async reset, active low
    input wire logic wr_en_in, // Register write strobe
    input wire logic rd_en_in, // Register read strobe
    input wire logic [7:0] addr_in, // Register address
    input wire logic [7:0] wdata_in, // Write data
    input wire logic test_done_in, // Detection run finished
    input wire logic open_fault_in, // Open LED seen
    input wire logic short_fault_in, // Shorted LED seen
    input wire logic frame_end_in, // Scroll frame finished
    input wire logic [2:0] led_sel_in, // Select field of scanned LED
    output logic [7:0] rdata_out, // Read data
    output logic int_n_out, // Interrupt, active low
    output logic detect_on_out, // Detection running
    output logic matrix_run_out, // Matrix operation forced on
    output logic [NUM_DRV-1:0] drive_out, // Shared driver gates
    output logic [4:0] repeat_out, // Duty repeats per scan
    output logic det_led_out // Scanned LED under test
);
    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [3:0] status_q;
    logic [3:0] status_d;
    logic [3:0] mask_q;
    logic detect_q;
    logic [7:0] drv_en_q;
    logic [7:0] pwm_q [NUM_DRV];
    logic [7:0] scale_q;
    logic [7:0] time_q [NUM_DRV];
    logic [$clog2(lmx_pkg::LMX_STEP_CYC+1)-1:0] div_q;
    logic step_q;
    logic [NUM_DRV-1:0] drv_gate;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_status = wr_en_in && addr_in == lmx_pkg::LMX_ADDR_STATUS;
    wire wr_mask = wr_en_in && addr_in == lmx_pkg::LMX_ADDR_MASK;
    wire wr_detect = wr_en_in && addr_in == lmx_pkg::LMX_ADDR_DETECT;
    wire wr_drv_en = wr_en_in && addr_in == lmx_pkg::LMX_ADDR_DRV_EN;
    wire wr_scale = wr_en_in && addr_in == lmx_pkg::LMX_ADDR_SCALE;
    wire in_pwm = addr_in >= lmx_pkg::LMX_ADDR_PWM1
        && addr_in <= lmx_pkg::LMX_ADDR_PWM7;
    wire [7:0] pwm_off = addr_in - lmx_pkg::LMX_ADDR_PWM1;
    wire in_time = addr_in > lmx_pkg::LMX_ADDR_SCALE
        && addr_in < lmx_pkg::LMX_ADDR_SEL_FIRST;
    wire [7:0] time_off = addr_in - lmx_pkg::LMX_ADDR_SCALE - 8'h01;
    wire [3:0] events = {test_done_in, open_fault_in, short_fault_in,
        frame_end_in};

    // Hardware set beats a same-cycle clear; writing one never sets
    assign status_d =
        (wr_status ? (status_q & wdata_in[3:0])
        : status_q)
        | events;

    ////////////////////////////////////////////////////////////////////////
    // Read data: detect register is write-only and reads zero
    wire [7:0] rd_word =
        (addr_in == lmx_pkg::LMX_ADDR_STATUS) ? {4'h0, status_q} :
        (addr_in == lmx_pkg::LMX_ADDR_MASK) ? {4'h0, mask_q} :
        (addr_in == lmx_pkg::LMX_ADDR_DRV_EN) ? drv_en_q :
        in_pwm ? pwm_q[pwm_off[2:0]] :
        (addr_in == lmx_pkg::LMX_ADDR_SCALE) ? scale_q :
        in_time ? time_q[time_off[2:0]] : 8'h00;

    // Scan-time select decode for detection and default brightness
    wire sel_det = detect_q && (led_sel_in == lmx_pkg::LMX_SEL_DET_ON
        || led_sel_in == lmx_pkg::LMX_SEL_OPEN
        || led_sel_in == lmx_pkg::LMX_SEL_SHORT);
    wire [4:0] rpt = (led_sel_in == 3'h0)
        ? ({1'b0, scale_q[3:0]} + 5'h01) : 5'h01;
    wire [NUM_DRV-1:0] sel_hot = (led_sel_in == 3'h0 || detect_q)
        ? '0 : NUM_DRV'(1) << (led_sel_in - 3'h1);

    ////////////////////////////////////////////////////////////////////////
    // Control and status registers
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            status_q <= lmx_pkg::LMX_RST_STATUS[3:0];
            mask_q <= lmx_pkg::LMX_RST_MASK[3:0];
            detect_q <= 1'b0;
            drv_en_q <= lmx_pkg::LMX_RST_ZERO;
            scale_q <= lmx_pkg::LMX_RST_ZERO;
        end
        else
        begin
            status_q <= status_d;
            if (wr_mask)
                mask_q <= wdata_in[3:0];
            if (wr_detect)
                detect_q <= wdata_in[0];
            if (wr_drv_en)
                drv_en_q <= wdata_in;
            if (wr_scale)
                scale_q <= wdata_in;
        end
    end

    // Per-driver PWM and time registers, indexed by address offset
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < NUM_DRV; i++)
            begin
                pwm_q[i] <= lmx_pkg::LMX_RST_ZERO;
                time_q[i] <= lmx_pkg::LMX_RST_ZERO;
            end
        end
        else if (wr_en_in)
        begin
            if (in_pwm)
                pwm_q[pwm_off[2:0]] <= {1'b0, wdata_in[6:0]};
            if (in_time)
                time_q[time_off[2:0]] <= {1'b0, wdata_in[6:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step time base, shared by all drivers to keep them in phase
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            div_q <= '0;
            step_q <= 1'b0;
        end
        else
        begin
            step_q <= div_q == '0;
            div_q <= (div_q == '0) ? $bits(div_q)'(lmx_pkg::LMX_STEP_CYC - 1)
                : div_q - 1'b1;
        end
    end

    // Seven shared drivers
    for (genvar g = 0; g < NUM_DRV; g++)
    begin : g_drv
        lmx_pwm #(
            .DUTY_W(DUTY_W)
        ) u_pwm (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .step_in(step_q),
            .on_in(drv_en_q[g]),
            .pwm_on_in(pwm_q[g][lmx_pkg::LMX_BIT_PWM_ON]),
            .duty_in(pwm_q[g][DUTY_W-1:0]),
            .time_in(time_q[g][6:4]),
            .fade_dbl_in(drv_en_q[lmx_pkg::LMX_BIT_FADE_DBL]),
            .hi_scale_in(scale_q[7:6]),
            .lo_scale_in(scale_q[5:4]),
            .drive_out(drv_gate[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_out <= 8'h00;
            int_n_out <= 1'b1;
            detect_on_out <= 1'b0;
            matrix_run_out <= 1'b0;
            drive_out <= '0;
            repeat_out <= 5'h01;
            det_led_out <= 1'b0;
        end
        else
        begin
            if (rd_en_in)
                rdata_out <= rd_word;
            int_n_out <= ~|(status_d & ~mask_q);
            detect_on_out <= detect_q;
            matrix_run_out <= detect_q;
            drive_out <= drv_gate & sel_hot;
            repeat_out <= rpt;
            det_led_out <= sel_det;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_clr_write;
        wr_status && !wdata_in[lmx_pkg::LMX_BIT_OPEN] && !open_fault_in;
    endsequence

    property p_test_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        test_done_in |=> status_q[lmx_pkg::LMX_BIT_TEST];
    endproperty
    a_test_set: assert property (p_test_set)
        else $error("test flag lost");

    property p_open_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        open_fault_in |=> status_q[lmx_pkg::LMX_BIT_OPEN];
    endproperty
    a_open_set: assert property (p_open_set)
        else $error("open flag lost");

    property p_short_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        short_fault_in |=> status_q[lmx_pkg::LMX_BIT_SHORT];
    endproperty
    a_short_set: assert property (p_short_set)
        else $error("short flag lost");

    property p_frame_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        frame_end_in |=> status_q[lmx_pkg::LMX_BIT_FRAME];
    endproperty
    a_frame_set: assert property (p_frame_set)
        else $error("frame flag lost");

    property p_int_follows;
        @(posedge mclk_in) disable iff (!rst_n_in)
        ##1 (int_n_out == ~|($past(status_d) & ~$past(mask_q)));
    endproperty
    a_int_follows: assert property (p_int_follows)
        else $error("int wrong");

    property p_clear;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_clr_write |=> !status_q[lmx_pkg::LMX_BIT_OPEN];
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear failed");

    property p_no_sw_set;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (!status_q[lmx_pkg::LMX_BIT_TEST] && !test_done_in)
            |=> !status_q[lmx_pkg::LMX_BIT_TEST];
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("flag self set");

    property p_sticky;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (status_q[lmx_pkg::LMX_BIT_SHORT] && !wr_status)
            |=> status_q[lmx_pkg::LMX_BIT_SHORT] [*1];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped");

    property p_detect_run;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_detect && wdata_in[0]) |=> ##1 (matrix_run_out && detect_on_out);
    endproperty
    a_detect_run: assert property (p_detect_run)
        else $error("no run");

    ////////////////////////////////////////////////////////////////////////
    // Register write checks; each write must land one edge later
    property p_mask_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        wr_mask |=> mask_q == $past(wdata_in[3:0]);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write lost");

    property p_detect_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_detect && !wdata_in[0]) |=> !detect_q;
    endproperty
    a_detect_off: assert property (p_detect_off)
        else $error("detection stuck on");

    property p_drv_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        wr_drv_en |=> drv_en_q == $past(wdata_in);
    endproperty
    a_drv_write: assert property (p_drv_write)
        else $error("enable write lost");

    // Bit 7 of a control byte never sticks
    property p_pwm_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (wr_en_in && addr_in == lmx_pkg::LMX_ADDR_PWM7)
            |=> pwm_q[NUM_DRV-1] == {1'b0, $past(wdata_in[6:0])};
    endproperty
    a_pwm_write: assert property (p_pwm_write)
        else $error("control write lost");

    // Interrupt stays high while every flag is masked
    property p_int_quiet;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (mask_q == 4'hF) |=> int_n_out;
    endproperty
    a_int_quiet: assert property (p_int_quiet)
        else $error("masked interrupt seen");

    ////////////////////////////////////////////////////////////////////////
    // Driver gate checks, two flops behind the enable
    sequence s_drv1_off;
        !drv_en_q[0] ##1 1'b1;
    endsequence

    property p_gate_off;
        @(posedge mclk_in) disable iff (!rst_n_in)
        s_drv1_off |=> !drive_out[0];
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("gate on while driver off");

    property p_detect_gates;
        @(posedge mclk_in) disable iff (!rst_n_in)
        detect_q |=> (drive_out == '0);
    endproperty
    a_detect_gates: assert property (p_detect_gates)
        else $error("gate on during detection");

    ////////////////////////////////////////////////////////////////////////
    // Scan-time decode checks
    property p_repeat_other;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (led_sel_in != 3'h0) |=> (repeat_out == 5'h01);
    endproperty
    a_repeat_other: assert property (p_repeat_other)
        else $error("repeat on driven LED");

    property p_repeat_max;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (led_sel_in == 3'h0 && scale_q[3:0] == 4'hF)
            |=> (repeat_out == 5'h10);
    endproperty
    a_repeat_max: assert property (p_repeat_max)
        else $error("repeat count short");

    property p_det_open;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (detect_q && led_sel_in == lmx_pkg::LMX_SEL_OPEN) |=> det_led_out;
    endproperty
    a_det_open: assert property (p_det_open)
        else $error("open LED not flagged");

    property p_det_idle;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !detect_q |=> !det_led_out;
    endproperty
    a_det_idle: assert property (p_det_idle)
        else $error("LED flagged without detection");
endmodule : lmx_regs

//--- sim/lmx_host.sv
// Host controller model that reaches the register bank byte by byte.
// Assumes one-cycle strobes and read data one edge after the read.
`timescale 1ns/10ps
module lmx_host (
    input wire logic mclk_in, // System clock
    input wire logic [7:0] rdata_in, // Read data from the bank
    output logic wr_en_out, // Write strobe
    output logic rd_en_out, // Read strobe
    output logic [7:0] addr_out, // Register address
    output logic [7:0] wdata_out // Write data
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus shows junk, never a stale value
    initial
    begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = 8'hA5;
        wdata_out = 8'h5A;
    end

    // One write; a zero clears a flag, detection is set alone
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1;
        wr_en_out = 1'b1;
        addr_out = a;
        wdata_out = d;
        @(posedge mclk_in);
        #1;
        wr_en_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask : wr

    // One read; data is taken at the edge that takes the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        #1;
        rd_en_out = 1'b1;
        addr_out = a;
        @(posedge mclk_in);
        #1;
        d = rdata_in;
        rd_en_out = 1'b0;
        addr_out = ~a;
    endtask : rd
endmodule : lmx_host

//--- sim/test_led_matrix_irq_pwm_regs.sv
// Self-checking bench for the LED matrix register bank.
// Assumes the bank answers reads one edge later and outputs are registered.
`timescale 1ns/10ps
module test_led_matrix_irq_pwm_regs;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wr_en, rd_en, int_n, detect_on, matrix_run, det_led;
    logic [7:0] addr, wdata, rdata;
    logic [3:0] ev = 4'h0;
    logic [2:0] led_sel = 3'h0;
    logic [6:0] drive;
    logic [4:0] rpt;
    int err_total = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock of 4 ns
    always #2 mclk_in = ~mclk_in;

    lmx_host lmx_host_i (.mclk_in(mclk_in), .rdata_in(rdata),
        .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
        .wdata_out(wdata));

    lmx_regs lmx_regs_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
        .wdata_in(wdata), .test_done_in(ev[3]), .open_fault_in(ev[2]),
        .short_fault_in(ev[1]), .frame_end_in(ev[0]),
        .led_sel_in(led_sel), .rdata_out(rdata), .int_n_out(int_n),
        .detect_on_out(detect_on), .matrix_run_out(matrix_run),
        .drive_out(drive), .repeat_out(rpt), .det_led_out(det_led));

    ////////////////////////////////////////////////////////////////////////
    // Compare, count, report
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
        input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %0t %s seen %h expected %h", $time, msg,
                seen, exp);
        end
    endtask : chk

    task automatic conclude();
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // Inputs move 1 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : tick

    // Bounded look at the driver gates; ORs every cycle seen
    task automatic watch(input int n, output logic [7:0] seen,
        output logic [7:0] hi);
        seen = 8'h00;
        hi = 8'h00;
        repeat (n)
        begin
            tick(1);
            seen = seen | {1'b0, drive};
            hi = hi + {7'h00, drive[0]};
        end
    endtask : watch

    ////////////////////////////////////////////////////////////////////////
    // Reset values, write-only and unmapped places
    task automatic t_reset();
        logic [7:0] v;
        logic [7:0] ad [7] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E,
            8'h25, 8'h80};
        logic [7:0] ex [7] = '{8'h00, 8'h0F, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00};
        chk({4'h0, int_n, detect_on, matrix_run, det_led}, 8'h08,
            "rst o");
        chk({3'h0, rpt}, 8'h01, "rst repeat");
        chk({1'b0, drive}, 8'h00, "rst drive");
        lmx_host_i.wr(8'h80, 8'hFF);
        for (int i = 0; i < 7; i++)
        begin
            lmx_host_i.rd(ad[i], v);
            chk(v, ex[i], "rst read");
        end
    endtask : t_reset

    // Each flag: set, masked, unmasked, sticky, write-one, clear
    task automatic t_flags();
        logic [7:0] v;
        for (int b = 0; b < 4; b++)
        begin
            ev = 4'h1 << b;
            tick(1);
            ev = 4'h0;
            tick(2);
            chk({7'h0, int_n}, 8'h01, "masked int");
            lmx_host_i.wr(8'h1B, ~(8'h01 << b));
            tick(1);
            chk({7'h0, int_n}, 8'h00, "int missing");
            lmx_host_i.wr(8'h1A, 8'hFF);
            lmx_host_i.rd(8'h1A, v);
            chk(v, 8'h01 << b,
                "flag");
            lmx_host_i.wr(8'h1A, ~(8'h01 << b));
            lmx_host_i.rd(8'h1A, v);
            chk(v, 8'h00, "clear");
            chk({7'h0, int_n}, 8'h01, "int after clear");
        end
        lmx_host_i.wr(8'h1B, 8'hFF);
        lmx_host_i.rd(8'h1B, v);
        chk(v, 8'h0F, "mask bits");
    endtask : t_flags

    // Detection enable, matrix start, per-LED detection codes
    task automatic t_detect();
        logic [7:0] v;
        lmx_host_i.wr(8'h1C, 8'h01);
        tick(1);
        chk({6'h0, detect_on, matrix_run}, 8'h03,
            "det on");
        lmx_host_i.rd(8'h1C, v);
        chk(v, 8'h00, "write-only");
        for (int s = 0; s < 8; s++)
        begin
            led_sel = 3'(s);
            tick(2);
            chk({7'h0, det_led}, 8'(s >= 4 && s <= 6), "det led");
        end
        lmx_host_i.wr(8'h1C, 8'h00);
        tick(1);
        chk({6'h0, detect_on, matrix_run}, 8'h00, "det off");
    endtask : t_detect

    // Driver enables, PWM registers, duty extremes
    task automatic t_drivers();
        logic [7:0] v;
        logic [7:0] h;
        lmx_host_i.wr(8'h1D, 8'hFF);
        lmx_host_i.rd(8'h1D, v);
        chk(v, 8'hFF, "enables");
        for (int i = 0; i < 7; i++)
        begin
            lmx_host_i.wr(8'h1E + 8'(i), 8'hC0 | 8'(i * 9));
            lmx_host_i.rd(8'h1E + 8'(i), v);
            chk(v, 8'h40 | 8'(i * 9), "pwm reg");
        end
        led_sel = 3'h1;
        lmx_host_i.wr(8'h1E, 8'h40);
        watch(2000, v, h);
        chk(v, 8'h00, "duty zero");
        lmx_host_i.wr(8'h1E, 8'h7F);
        watch(2000, v, h);
        chk(v, 8'h01, "duty full");
        watch(64, v, h);
        chk(h, 8'h3F, "duty ratio");
        lmx_host_i.wr(8'h1D, 8'h00);
        tick(2);
        watch(300, v, h);
        chk(v, 8'h00, "drivers off");
        // Firefly ramps slowly, so the gate is nearly dark at first
        lmx_host_i.wr(8'h1E, 8'h3F);
        lmx_host_i.wr(8'h26, 8'h10);
        lmx_host_i.wr(8'h1D, 8'h01);
        tick(300);
        watch(64, v, h);
        chk(8'(h < 8'h08), 8'h01, "firefly ramp");
    endtask : t_drivers

    // Every scale code and brightness repeat counts 1, 6, 11 and 16
    task automatic t_scale();
        logic [7:0] v;
        logic [7:0] d;
        led_sel = 3'h0;
        for (int j = 0; j < 4; j++)
        begin
            d = {2'(j), 2'(3 - j), 4'(j * 5)};
            lmx_host_i.wr(8'h25, d);
            lmx_host_i.rd(8'h25, v);
            chk(v, d, "scale");
            tick(2);
            chk({3'h0, rpt}, 8'(j * 5 + 1), "repeat");
        end
        led_sel = 3'h1;
        tick(2);
        chk({3'h0, rpt}, 8'h01, "repeat other");
    endtask : t_scale

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; hang guard counts as a mismatch
    initial
    begin
        tick(6);
        rst_n_in = 1'b1;
        t_reset();
        t_flags();
        t_detect();
        t_drivers();
        t_scale();
        conclude();
    end

    initial
    begin
        #200000;
        err_total++;
        conclude();
    end
endmodule : test_led_matrix_irq_pwm_regs
